// [hdl/crce_pkg.sv]
// constants and types shared by both ends of the crc engine link
// assumes a 32-bit apb data path and 12-bit register offsets
package crce_pkg;

    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;

    // register byte offsets
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_CMD = 12'h004;
    localparam logic [11:0] OFS_SEED = 12'h008;
    localparam logic [11:0] OFS_POLY = 12'h00c;
    localparam logic [11:0] OFS_WORD_IN = 12'h010;
    localparam logic [11:0] OFS_HALF_IN = 12'h014;
    localparam logic [11:0] OFS_BYTE_IN = 12'h018;
    localparam logic [11:0] OFS_RES_REFL = 12'h01c;
    localparam logic [11:0] OFS_RES_NORM = 12'h020;
    localparam logic [11:0] OFS_RES_BSWP = 12'h024;

    // crc_control field positions
    localparam int unsigned CTRL_EN_BIT = 0;
    localparam int unsigned CTRL_POLY_SEL_BIT = 4;
    localparam int unsigned CTRL_BYTE_ONLY_BIT = 8;
    localparam int unsigned CTRL_BIT_FLIP_BIT = 9;
    localparam int unsigned CTRL_BYTE_SWAP_BIT = 10;
    localparam int unsigned CTRL_AUTO_SEED_BIT = 13;
    // crc_command field position
    localparam int unsigned CMD_INIT_BIT = 0;
    // crc_generator_poly top bit, the x^0 term
    localparam int unsigned POLY16_MSB_BIT = 15;

    // reset values
    localparam logic CTRL_FIELD_RST = 1'b0;
    localparam logic [31:0] SEED_RST = 32'h00000000;
    localparam logic [15:0] POLY_RST = 16'h0000;
    localparam logic [31:0] CRC_RST = 32'h00000000;

    // poly_width_select encoding and fixed polynomial
    localparam logic POLY_SEL_FIXED32 = 1'b0;
    localparam logic POLY_SEL_PROG16 = 1'b1;
    localparam logic [31:0] POLY32 = 32'h04c11db7;

    typedef enum logic [1:0] {
        CRCE_W32,
        CRCE_W16,
        CRCE_W8
    } crce_width_t;

endpackage

// [hdl/crce_apb_if.sv]
// apb link between the crc engine host and the crc engine
// assumes both ends run on the same clock, given to each module
`timescale 1ns/1ps
`default_nettype none
interface crce_apb_if;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;

    modport dev (
        input psel, penable, pwrite, paddr, pwdata,
        output prdata, pready, pslverr
    );

    modport host (
        output psel, penable, pwrite, paddr, pwdata,
        input prdata, pready, pslverr
    );
endinterface
`default_nettype wire

// [hdl/crce_crc_step.sv]
// one-cycle reflected crc update over 32, 16 or 8 input bits
// assumes input data already reordered; purely combinational
`timescale 1ns/1ps
`default_nettype none
module crce_crc_step (
    input wire logic [31:0] crc_in,
    input wire logic [31:0] data_in,
    input wire crce_pkg::crce_width_t width_in,
    input wire logic poly_sel_in,
    input wire logic [15:0] poly16_in,
    output logic [31:0] crc_out
);
    logic [31:0] poly32_refl;
    logic [31:0] poly_used;
    logic [5:0] nbits;

    genvar g;
    for (g = 0; g < 32; g++) begin : g_rev
        assign poly32_refl[g] = crce_pkg::POLY32[31 - g];
    end

    always_comb begin
        logic [31:0] c;
        logic fb;
        c = crc_in;
        fb = 1'b0;
        case (width_in)
            crce_pkg::CRCE_W16: nbits = 6'h10;
            crce_pkg::CRCE_W8: nbits = 6'h08;
            default: nbits = 6'h20;
        endcase
        // reflected poly: msb is x^0, x^16 (16-bit) or x^32 (32-bit) implicit
        if (poly_sel_in == crce_pkg::POLY_SEL_PROG16) begin
            poly_used = {16'h0000, poly16_in};
            c = {16'h0000, crc_in[15:0]};
        end else begin
            poly_used = poly32_refl;
        end
        // lsb first, right shifting
        for (int i = 0; i < 32; i++) begin
            if (i < int'(nbits)) begin
                fb = c[0] ^ data_in[i];
                c = {1'b0, c[31:1]};
                if (fb) begin
                    c = c ^ poly_used;
                end
            end
        end
        crc_out = c;
    end
endmodule // crce_crc_step
`default_nettype wire

// [hdl/crce_dev.sv]
// crc engine: apb slave register file and single-cycle crc datapath
// assumes an apb master on the link and one shared synchronous reset
// Summary of operation
// - fixed 32-bit polynomial when 32-bit selected
// - programmable register gives the 16-bit polynomial
// - x^16 term implicit, sixteen bits stored
// - polynomial reflected: msb x^0, lsb x^15
// - host sets polynomial top bit to one
// - three input registers fold data into crc
// - host writes input matching data width
// - byte mode uses only lowest byte
// - reflected and normal order result reads
// - one-cycle update stalls result reads, commands
// - seed register then init command loads crc
// - auto seed reloads crc after result reads
// - host uses word-aligned addresses for inputs
// - words by dma, tail bytes by software
// - reorder and bit flip precede crc
// - byte inputs skip swap, keep bit flip
// - halfword swap exchanges low bytes, clears upper
// - word swap reverses bytes, flips combine
// - disabled engine only reorders, no update
// - select zero fixed 32, one programmable 16
`timescale 1ns/1ps
`default_nettype none
module crce_dev (
    input wire logic CORE_CLK_IN,
    input wire logic SRST_IN,
    crce_apb_if.dev APB,
    output logic [31:0] CRC_RESULT_OUT,
    output logic CRC_BUSY_OUT
);
    typedef struct packed {
        logic en;
        logic poly_width_select;
        logic byte_only_input;
        logic per_byte_bit_flip;
        logic byte_order_swap;
        logic auto_seed_on_read;
        logic [31:0] seed;
        logic [15:0] poly;
        logic [31:0] crc;
        logic [31:0] data;
        crce_pkg::crce_width_t width;
        logic busy;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } crce_dev_st_t;

    crce_dev_st_t s_q;
    crce_dev_st_t s_d;

    logic [31:0] step_out;
    logic [31:0] shaped;
    logic [31:0] flipped;
    logic [31:0] rev32;
    logic [15:0] rev16;
    logic [31:0] res_norm;
    logic [31:0] res_bswp;
    logic [31:0] ctrl_rd;
    logic [31:0] rd_mux;
    crce_pkg::crce_width_t in_width;
    logic is_input;
    logic is_result;
    logic mapped;
    logic stall;
    logic done;
    logic [31:0] w;
    logic [11:0] a;

    assign w = APB.pwdata;
    assign a = APB.paddr;

    // input width from register written, byte mode overrides
    always_comb begin
        is_input = 1'b1;
        case (a)
            crce_pkg::OFS_WORD_IN: in_width = crce_pkg::CRCE_W32;
            crce_pkg::OFS_HALF_IN: in_width = crce_pkg::CRCE_W16;
            crce_pkg::OFS_BYTE_IN: in_width = crce_pkg::CRCE_W8;
            default: begin
                in_width = crce_pkg::CRCE_W32;
                is_input = 1'b0;
            end
        endcase
        if (s_q.byte_only_input) begin
            in_width = crce_pkg::CRCE_W8;
        end
    end

    // byte reordering ahead of the crc
    always_comb begin
        case (in_width)
            crce_pkg::CRCE_W16: begin
                if (s_q.byte_order_swap) begin
                    shaped = {16'h0000, w[7:0], w[15:8]};
                end else begin
                    shaped = {16'h0000, w[15:0]};
                end
            end
            crce_pkg::CRCE_W8: shaped = {24'h000000, w[7:0]};
            default: begin
                if (s_q.byte_order_swap) begin
                    shaped = {w[7:0], w[15:8], w[23:16], w[31:24]};
                end else begin
                    shaped = w;
                end
            end
        endcase
    end

    // per-byte bit flip and result bit reversal
    genvar g;
    for (g = 0; g < 32; g++) begin : g_bits
        assign flipped[g] = s_q.per_byte_bit_flip ?
            shaped[(g & ~7) + 7 - (g & 7)] : shaped[g];
        assign rev32[g] = s_q.crc[31 - g];
        if (g < 16) begin : g_rev16
            assign rev16[g] = s_q.crc[15 - g];
        end
    end

    // result views for 32 and 16 bit operation
    always_comb begin
        if (s_q.poly_width_select == crce_pkg::POLY_SEL_PROG16) begin
            res_norm = {16'h0000, rev16};
            res_bswp = {16'h0000, s_q.crc[7:0], s_q.crc[15:8]};
        end else begin
            res_norm = rev32;
            res_bswp = {s_q.crc[7:0], s_q.crc[15:8], s_q.crc[23:16], s_q.crc[31:24]};
        end
    end

    always_comb begin
        ctrl_rd = 32'h00000000;
        ctrl_rd[crce_pkg::CTRL_EN_BIT] = s_q.en;
        ctrl_rd[crce_pkg::CTRL_POLY_SEL_BIT] = s_q.poly_width_select;
        ctrl_rd[crce_pkg::CTRL_BYTE_ONLY_BIT] = s_q.byte_only_input;
        ctrl_rd[crce_pkg::CTRL_BIT_FLIP_BIT] = s_q.per_byte_bit_flip;
        ctrl_rd[crce_pkg::CTRL_BYTE_SWAP_BIT] = s_q.byte_order_swap;
        ctrl_rd[crce_pkg::CTRL_AUTO_SEED_BIT] = s_q.auto_seed_on_read;
    end

    // read mux and address decode
    always_comb begin
        mapped = 1'b1;
        is_result = 1'b0;
        case (a)
            crce_pkg::OFS_CTRL: rd_mux = ctrl_rd;
            crce_pkg::OFS_CMD: rd_mux = 32'h00000000;
            crce_pkg::OFS_SEED: rd_mux = s_q.seed;
            crce_pkg::OFS_POLY: rd_mux = {16'h0000, s_q.poly};
            crce_pkg::OFS_WORD_IN, crce_pkg::OFS_HALF_IN,
            crce_pkg::OFS_BYTE_IN: rd_mux = 32'h00000000;
            crce_pkg::OFS_RES_REFL: begin
                rd_mux = s_q.crc;
                is_result = 1'b1;
            end
            crce_pkg::OFS_RES_NORM: begin
                rd_mux = res_norm;
                is_result = 1'b1;
            end
            crce_pkg::OFS_RES_BSWP: begin
                rd_mux = res_bswp;
                is_result = 1'b1;
            end
            default: begin
                rd_mux = 32'h00000000;
                mapped = 1'b0;
            end
        endcase
    end

    crce_crc_step crce_crc_step_i (
        .crc_in(s_q.crc),
        .data_in(s_q.data),
        .width_in(s_q.width),
        .poly_sel_in(s_q.poly_width_select),
        .poly16_in(s_q.poly),
        .crc_out(step_out)
    );

    // hold result reads and command writes during an update
    assign stall = s_q.busy & ((!APB.pwrite & is_result)
        | (APB.pwrite & (a == crce_pkg::OFS_CMD)));
    assign done = APB.psel & APB.penable & s_q.pready;

    always_comb begin
        s_d = s_q;
        s_d.busy = 1'b0;
        if (s_q.busy) begin
            s_d.crc = step_out;
        end
        s_d.pready = APB.psel & !done & !stall;
        if (s_d.pready & !s_q.pready) begin
            s_d.prdata = APB.pwrite ? 32'h00000000 : rd_mux;
            s_d.pslverr = !mapped;
        end
        if (done) begin
            s_d.pslverr = 1'b0;
        end
        if (done & APB.pwrite & mapped) begin
            case (a)
                crce_pkg::OFS_CTRL: begin
                    s_d.en = w[crce_pkg::CTRL_EN_BIT];
                    s_d.per_byte_bit_flip = w[crce_pkg::CTRL_BIT_FLIP_BIT];
                    s_d.byte_order_swap = w[crce_pkg::CTRL_BYTE_SWAP_BIT];
                    // disabled engine: only enable and reorder settings take
                    if (w[crce_pkg::CTRL_EN_BIT] | s_q.en) begin
                        s_d.poly_width_select = w[crce_pkg::CTRL_POLY_SEL_BIT];
                        s_d.byte_only_input = w[crce_pkg::CTRL_BYTE_ONLY_BIT];
                        s_d.auto_seed_on_read = w[crce_pkg::CTRL_AUTO_SEED_BIT];
                    end
                end
                crce_pkg::OFS_CMD: begin
                    if (w[crce_pkg::CMD_INIT_BIT]) begin
                        s_d.crc = s_q.seed;
                    end
                end
                crce_pkg::OFS_SEED: s_d.seed = w;
                crce_pkg::OFS_POLY: s_d.poly = w[15:0];
                default: begin
                    if (is_input) begin
                        s_d.data = flipped;
                        s_d.width = in_width;
                        s_d.busy = s_q.en;
                    end
                end
            endcase
        end
        if (done & !APB.pwrite & is_result & s_q.auto_seed_on_read) begin
            s_d.crc = s_q.seed;
        end
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (SRST_IN) begin
            s_q.en <= crce_pkg::CTRL_FIELD_RST;
            s_q.poly_width_select <= crce_pkg::CTRL_FIELD_RST;
            s_q.byte_only_input <= crce_pkg::CTRL_FIELD_RST;
            s_q.per_byte_bit_flip <= crce_pkg::CTRL_FIELD_RST;
            s_q.byte_order_swap <= crce_pkg::CTRL_FIELD_RST;
            s_q.auto_seed_on_read <= crce_pkg::CTRL_FIELD_RST;
            s_q.seed <= crce_pkg::SEED_RST;
            s_q.poly <= crce_pkg::POLY_RST;
            s_q.crc <= crce_pkg::CRC_RST;
            s_q.data <= 32'h00000000;
            s_q.width <= crce_pkg::CRCE_W32;
            s_q.busy <= 1'b0;
            s_q.pready <= 1'b0;
            s_q.pslverr <= 1'b0;
            s_q.prdata <= 32'h00000000;
        end else begin
            s_q <= s_d;
        end
    end

    assign APB.pready = s_q.pready;
    assign APB.pslverr = s_q.pslverr;
    assign APB.prdata = s_q.prdata;
    // status toward the user side, straight from the state register
    assign CRC_RESULT_OUT = s_q.crc;
    assign CRC_BUSY_OUT = s_q.busy;
endmodule // crce_dev
`default_nettype wire

// [hdl/crce_host.sv]
// apb master end: turns one user command into one apb transfer
// assumes the crc engine on the link answers with pready, same clock
`timescale 1ns/1ps
`default_nettype none
module crce_host (
    input wire logic CORE_CLK_IN,
    input wire logic SRST_IN,
    crce_apb_if.host APB,
    input wire logic CMD_VALID_IN,
    input wire logic CMD_WRITE_IN,
    input wire logic [11:0] CMD_ADDR_IN,
    input wire logic [31:0] CMD_WDATA_IN,
    output logic CMD_READY_OUT,
    output logic RSP_VALID_OUT,
    output logic [31:0] RSP_RDATA_OUT,
    output logic RSP_ERR_OUT
);
    typedef enum logic [1:0] {
        H_IDLE,
        H_SETUP,
        H_ACCESS
    } crce_host_state_t;

    typedef struct packed {
        crce_host_state_t state;
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
        logic cmd_ready;
        logic rsp_valid;
        logic [31:0] rsp_rdata;
        logic rsp_err;
    } crce_host_st_t;

    crce_host_st_t s_q;
    crce_host_st_t s_d;

    always_comb begin
        s_d = s_q;
        s_d.rsp_valid = 1'b0;
        case (s_q.state)
            H_IDLE: begin
                s_d.cmd_ready = 1'b1;
                if (CMD_VALID_IN & s_q.cmd_ready) begin
                    s_d.cmd_ready = 1'b0;
                    s_d.psel = 1'b1;
                    s_d.penable = 1'b0;
                    s_d.pwrite = CMD_WRITE_IN;
                    s_d.paddr = {CMD_ADDR_IN[11:2], 2'b00};
                    s_d.pwdata = CMD_WDATA_IN;
                    if (CMD_WRITE_IN & ({CMD_ADDR_IN[11:2], 2'b00} == crce_pkg::OFS_POLY)) begin
                        s_d.pwdata[crce_pkg::POLY16_MSB_BIT] = 1'b1;
                    end
                    s_d.state = H_SETUP;
                end
            end
            H_SETUP: begin
                s_d.penable = 1'b1;
                s_d.state = H_ACCESS;
            end
            H_ACCESS: begin
                // wait for the engine, which may stall during an update
                if (APB.pready) begin
                    s_d.psel = 1'b0;
                    s_d.penable = 1'b0;
                    s_d.rsp_valid = 1'b1;
                    s_d.rsp_rdata = APB.prdata;
                    s_d.rsp_err = APB.pslverr;
                    s_d.cmd_ready = 1'b1;
                    s_d.state = H_IDLE;
                end
            end
            default: s_d.state = H_IDLE;
        endcase
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (SRST_IN) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign APB.psel = s_q.psel;
    assign APB.penable = s_q.penable;
    assign APB.pwrite = s_q.pwrite;
    assign APB.paddr = s_q.paddr;
    assign APB.pwdata = s_q.pwdata;
    assign CMD_READY_OUT = s_q.cmd_ready;
    assign RSP_VALID_OUT = s_q.rsp_valid;
    assign RSP_RDATA_OUT = s_q.rsp_rdata;
    assign RSP_ERR_OUT = s_q.rsp_err;
endmodule // crce_host
`default_nettype wire

// [dv/crce_chk.sv]
// apb link checks between the crc host end and the crc engine
// assumes instantiation beside the interface, one clock and reset
`timescale 1ns/1ps
`default_nettype none
module crce_chk (
    input wire logic CORE_CLK_IN,
    input wire logic SRST_IN,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    logic acc;
    logic wr_in_q;
    logic [15:0] poly_q;
    logic [31:0] seed_q;
    assign acc = psel && penable && pready;
    always_ff @(posedge CORE_CLK_IN) begin
        if (SRST_IN) begin
            wr_in_q <= 1'b0;
            poly_q <= 16'h0000;
            seed_q <= 32'h00000000;
        end else begin
            wr_in_q <= acc && pwrite && paddr >= 12'h010 && paddr <= 12'h018;
            if (acc && pwrite && paddr == crce_pkg::OFS_POLY) begin
                poly_q <= pwdata[15:0];
            end
            if (acc && pwrite && paddr == crce_pkg::OFS_SEED) begin
                seed_q <= pwdata;
            end
        end
    end
    default clocking dc @(posedge CORE_CLK_IN); endclocking
    default disable iff (SRST_IN);
    AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
        else $error("ready outside access phase");
    AST_READY_ONE_CYCLE: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    AST_ZERO_WAIT: assert property (psel && !penable && !wr_in_q |=> pready)
        else $error("wait state without a running update");
    AST_ERR_WITH_READY: assert property (pslverr |-> pready)
        else $error("error without ready");
    AST_UNMAPPED_ERR: assert property (acc && paddr > 12'h024 |-> pslverr)
        else $error("unmapped access not refused");
    AST_MAPPED_NO_ERR: assert property (acc && paddr <= 12'h024 |-> !pslverr)
        else $error("mapped access refused");
    AST_WO_READ_ZERO: assert property (acc && !pwrite && paddr inside {12'h004,
        12'h010, 12'h014, 12'h018} |-> prdata == 32'h00000000)
        else $error("write-only register read not zero");
    AST_POLY_BACK: assert property (acc && !pwrite && paddr == 12'h00c
        |-> prdata == {16'h0000, poly_q})
        else $error("polynomial readback differs");
    AST_SEED_BACK: assert property (acc && !pwrite && paddr == 12'h008
        |-> prdata == seed_q)
        else $error("seed readback differs");
endmodule // crce_chk
`default_nettype wire

// [dv/crce_tb_top.sv]
// self-checking bench: user commands into the host end, engine on the link
// assumes both ends share the bench clock and synchronous reset
`timescale 1ns/1ps
`default_nettype none
module crce_tb_top;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic c_valid = 1'b0;
    logic c_write = 1'b0;
    logic [11:0] c_addr = 12'h000;
    logic [31:0] c_wdata = 32'h00000000;
    logic c_ready, r_valid, r_err, rerr, busy;
    logic [31:0] r_rdata, rdata, crc_res;
    logic [15:0] poly_v = 16'h0000;
    int n_fail = 0;
    int tests_run = 0;
    int busy_n = 0;
    crce_apb_if apb();
    crce_host crce_host_i (.CORE_CLK_IN(clk), .SRST_IN(srst), .APB(apb),
        .CMD_VALID_IN(c_valid), .CMD_WRITE_IN(c_write), .CMD_ADDR_IN(c_addr),
        .CMD_WDATA_IN(c_wdata), .CMD_READY_OUT(c_ready), .RSP_VALID_OUT(r_valid),
        .RSP_RDATA_OUT(r_rdata), .RSP_ERR_OUT(r_err));
    crce_dev crce_dev_i (.CORE_CLK_IN(clk), .SRST_IN(srst), .APB(apb),
        .CRC_RESULT_OUT(crc_res), .CRC_BUSY_OUT(busy));
    crce_chk crce_chk_i (.CORE_CLK_IN(clk), .SRST_IN(srst), .psel(apb.psel),
        .penable(apb.penable), .pwrite(apb.pwrite), .paddr(apb.paddr),
        .pwdata(apb.pwdata), .prdata(apb.prdata), .pready(apb.pready),
        .pslverr(apb.pslverr));
    always #10 clk = ~clk;
    always @(posedge clk) begin
        if (busy === 1'b1) begin
            busy_n++;
        end
    end
    function automatic logic [31:0] prep(logic [31:0] d, int nb, logic fl, logic sw);
        logic [31:0] r;
        r = d;
        if (nb == 8) r = {24'h0, d[7:0]};
        else if (nb == 16) r = {16'h0, sw ? {d[7:0], d[15:8]} : d[15:0]};
        else if (sw) r = {d[7:0], d[15:8], d[23:16], d[31:24]};
        if (fl) for (int i = 0; i < 4; i++) r[8*i+:8] = {<<{r[8*i+:8]}};
        return r;
    endfunction
    function automatic logic [31:0] exp_crc(logic [31:0] c, logic [31:0] d, int nb, logic p16);
        logic [31:0] pr;
        pr = p16 ? {16'h0, poly_v} : 32'({<<{crce_pkg::POLY32}});
        if (p16) c = {16'h0, c[15:0]};
        for (int i = 0; i < nb; i++) c = (c >> 1) ^ ((c[0] ^ d[i]) ? pr : 32'h0);
        return c;
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        c_valid <= 1'b1;
        c_write <= w;
        c_addr <= a;
        c_wdata <= d;
        do begin @(posedge clk); n++; end while (c_ready !== 1'b1 && n < 100);
        c_valid <= 1'b0;
        do begin @(posedge clk); n++; end while (r_valid !== 1'b1 && n < 200);
        if (n >= 200) chk("response", 32'h1, 32'h0);
        rdata = r_rdata;
        rerr = r_err;
    endtask
    task automatic run_crc(input logic [31:0] ctl, input int nb, input logic [31:0] d,
        output logic [31:0] e);
        int b0, nbe;
        nbe = ctl[8] ? 8 : nb;
        xfer(1'b1, crce_pkg::OFS_CTRL, ctl);
        xfer(1'b1, crce_pkg::OFS_SEED, 32'h5a5a0ff0);
        xfer(1'b1, crce_pkg::OFS_CMD, 32'h1);
        b0 = busy_n;
        xfer(1'b1, nb == 32 ? crce_pkg::OFS_WORD_IN
            : nb == 16 ? crce_pkg::OFS_HALF_IN : crce_pkg::OFS_BYTE_IN, d);
        e = exp_crc(32'h5a5a0ff0, prep(d, nbe, ctl[9], ctl[10]), nbe, ctl[4]);
        xfer(1'b0, crce_pkg::OFS_RES_REFL, 32'h0);
        chk("reflected result", e, rdata);
        chk("busy pulses", 32'h1, 32'(busy_n - b0));
        if (!ctl[13]) chk("result port", e, crc_res);
    endtask
    task automatic t_regs;
        xfer(1'b0, crce_pkg::OFS_CTRL, 32'h0);
        chk("control reset", 32'h0, rdata);
        xfer(1'b0, 12'h028, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, rerr});
        xfer(1'b0, crce_pkg::OFS_CMD, 32'h0);
        chk("command read", 32'h0, rdata);
        xfer(1'b0, crce_pkg::OFS_BYTE_IN, 32'h0);
        chk("byte input read", 32'h0, rdata);
        xfer(1'b1, crce_pkg::OFS_CTRL, 32'h00002710);
        xfer(1'b0, crce_pkg::OFS_CTRL, 32'h0);
        chk("disabled control", 32'h00000600, rdata);
    endtask
    task automatic t_crc32;
        logic [31:0] e, c;
        for (int k = 0; k < 12; k++) begin
            c = 32'h1 | (32'(k % 2) << 9) | (32'((k / 2) % 2) << 10);
            run_crc(c, 32 >> (k / 4), 32'h1a2b3c4d + 32'(k * 32'h01030507), e);
            if (k < 4) begin
                xfer(1'b0, crce_pkg::OFS_RES_NORM, 32'h0);
                chk("normal result", 32'({<<{e}}), rdata);
                xfer(1'b0, crce_pkg::OFS_RES_BSWP, 32'h0);
                chk("swapped result", {e[7:0], e[15:8], e[23:16], e[31:24]}, rdata);
            end
        end
    endtask
    task automatic t_crc16;
        logic [31:0] e;
        poly_v = 16'h8408;
        xfer(1'b1, crce_pkg::OFS_POLY, {16'h0, poly_v & 16'h7fff});
        xfer(1'b0, crce_pkg::OFS_POLY, 32'h0);
        chk("polynomial readback", {16'h0, poly_v}, rdata);
        run_crc(32'h00000011, 16, 32'h0000c3a5, e);
        run_crc(32'h00000611, 32, 32'h87654321, e);
        xfer(1'b0, crce_pkg::OFS_RES_NORM, 32'h0);
        chk("normal result 16", {16'h0, 16'({<<{e[15:0]}})}, rdata);
        xfer(1'b0, crce_pkg::OFS_RES_BSWP, 32'h0);
        chk("swapped result 16", {16'h0, e[7:0], e[15:8]}, rdata);
    endtask
    task automatic t_byte_only_input;
        logic [31:0] e;
        run_crc(32'h00000701, 32, 32'hdeadbe96, e);
        run_crc(32'h00000101, 16, 32'h00005a3c, e);
    endtask
    task automatic t_autoseed;
        logic [31:0] e;
        run_crc(32'h00002001, 32, 32'h0badf00d, e);
        xfer(1'b0, crce_pkg::OFS_RES_BSWP, 32'h0);
        chk("auto seed swapped", 32'hf00f5a5a, rdata);
        xfer(1'b0, crce_pkg::OFS_RES_REFL, 32'h0);
        chk("auto seed", 32'h5a5a0ff0, rdata);
        xfer(1'b0, crce_pkg::OFS_SEED, 32'h0);
        chk("seed readback", 32'h5a5a0ff0, rdata);
    endtask
    task automatic t_disabled;
        logic [31:0] e;
        int b0;
        run_crc(32'h00000001, 32, 32'h13579bdf, e);
        xfer(1'b1, crce_pkg::OFS_CTRL, 32'h0);
        b0 = busy_n;
        xfer(1'b1, crce_pkg::OFS_WORD_IN, 32'h2468ace0);
        xfer(1'b0, crce_pkg::OFS_RES_REFL, 32'h0);
        chk("disabled result", e, rdata);
        chk("disabled busy", 32'h0, 32'(busy_n - b0));
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        print_verdict();
    end
    initial begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        t_regs();
        t_crc32();
        t_crc16();
        t_byte_only_input();
        t_autoseed();
        t_disabled();
        print_verdict();
    end
endmodule // crce_tb_top
`default_nettype wire
